//--- rtl/tsdc_pkg.sv
// Package with register offsets, field positions, reset values and carrier types of the sensor register bank.
package tsdc_pkg;

  // Register offsets of the byte-wide register port.
  localparam logic [7:0] TSDC_OFS_LOCAL_MSB  = 8'h00; // Local temperature high byte.
  localparam logic [7:0] TSDC_OFS_LOCAL_LSB  = 8'h30; // Local temperature low byte.
  localparam logic [7:0] TSDC_OFS_RSIGN_MSB  = 8'h01; // Signed remote temperature high byte.
  localparam logic [7:0] TSDC_OFS_RSIGN_LSB  = 8'h10; // Signed remote temperature low byte.
  localparam logic [7:0] TSDC_OFS_RUNS_MSB   = 8'h31; // Unsigned remote temperature high byte.
  localparam logic [7:0] TSDC_OFS_RUNS_LSB   = 8'h32; // Unsigned remote temperature low byte.
  localparam logic [7:0] TSDC_OFS_OFFSET_HI  = 8'h11; // Remote offset high byte.
  localparam logic [7:0] TSDC_OFS_OFFSET_LO  = 8'h12; // Remote offset low byte.
  localparam logic [7:0] TSDC_OFS_DIODE_CFG  = 8'hBF; // Diode configuration.
  localparam logic [7:0] TSDC_OFS_GEN_CFG_A  = 8'h03; // General configuration, first alias.
  localparam logic [7:0] TSDC_OFS_GEN_CFG_B  = 8'h09; // General configuration, second alias.
  localparam logic [7:0] TSDC_OFS_ONE_SHOT   = 8'h0F; // One-shot trigger, write only.

  // Reset values.
  localparam logic [7:0] TSDC_RST_DIODE_CFG  = 8'h1F;
  localparam logic [7:0] TSDC_RST_OFFSET     = 8'h00;
  localparam logic [7:0] TSDC_RST_GEN_CFG    = 8'h00;
  localparam logic [7:0] TSDC_RST_TEMP       = 8'h00;

  // Writable bit masks and fixed read values.
  localparam logic [7:0] TSDC_DCFG_WMASK     = 8'h7E; // Bits 6 to 1 are stored.
  localparam logic [7:0] TSDC_DCFG_FIXED     = 8'h01; // Bit 0 reads one, bit 7 reads zero.
  localparam logic [7:0] TSDC_OFFLO_WMASK    = 8'hE0; // Fraction bits 7 to 5.
  localparam logic [7:0] TSDC_GCFG_WMASK     = 8'h5E; // Bits 6, 4, 3, 2, 1.
  localparam logic [7:0] TSDC_UNMAPPED_DATA  = 8'h00;

  // Diode configuration field positions.
  localparam int TSDC_DCFG_PIN_FN    = 6;
  localparam int TSDC_DCFG_OS_FMASK  = 5;
  localparam int TSDC_DCFG_CR_FMASK  = 4;
  localparam int TSDC_DCFG_MODEL     = 3;
  localparam int TSDC_DCFG_FILT_HI   = 2;
  localparam int TSDC_DCFG_FILT_LO   = 1;
  localparam logic [1:0] TSDC_FILT_ON = 2'h3;

  // General configuration field positions.
  localparam int TSDC_GCFG_STANDBY   = 6;
  localparam int TSDC_GCFG_R_CRMASK  = 4;
  localparam int TSDC_GCFG_R_OSMASK  = 3;
  localparam int TSDC_GCFG_L_CRMASK  = 2;
  localparam int TSDC_GCFG_L_OSMASK  = 1;

  // Number of temperature channels with a high/low byte pair.
  localparam int TSDC_NCHAN = 3;

  // One register access from the serial bus engine.
  typedef struct packed {
    logic       rd;    // Read strobe, one cycle.
    logic       wr;    // Write strobe, one cycle.
    logic [7:0] addr;  // Register offset.
    logic [7:0] wdata; // Write data.
  } tsdc_req_t;

  // One finished conversion, all channels at once.
  typedef struct packed {
    logic       valid;
    logic [7:0] local_msb;
    logic [7:0] local_lsb;
    logic [7:0] rsign_msb;
    logic [7:0] rsign_lsb;
    logic [7:0] runs_msb;
    logic [7:0] runs_lsb;
  } tsdc_conv_t;

endpackage

//--- rtl/tsdc_regs.sv
// Register bank of the remote diode sensor: byte locking, diode and general configuration, remote offset.
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE_01] Host reads high byte before low byte.
// [RULE_02] High byte read freezes its low byte.
// [RULE_03] Low byte read releases the freeze.
// [RULE_04] Each high read refreezes, replacing older value.
// [RULE_05] Diode config bit 6 selects pin function.
// [RULE_06] Bit 5 masks diode fault from overtemp.
// [RULE_07] Bit 4 masks diode fault from critical.
// [RULE_08] Bit 3 selects remote diode model.
// [RULE_09] Filter field 00 off, 11 on.
// [RULE_10] Diode config resets 1Fh, bit7 0, bit0 1.
// [RULE_11] Offset high byte: sign and integer, reset zero.
// [RULE_12] Offset low byte: three fraction bits, reset zero.
// [RULE_13] One-shot write starts conversion only in standby.
// [RULE_14] General config standby and remote alert masks.
module tsdc_regs
  import tsdc_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // Register access from the serial bus engine.
  input  wire tsdc_req_t   req_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  // Conversion results and comparator states.
  input  wire tsdc_conv_t  conv_in,
  input  wire logic        remote_os_over_in,
  input  wire logic        remote_crit_over_in,
  input  wire logic        local_os_over_in,
  input  wire logic        local_crit_over_in,
  input  wire logic        diode_fault_in,
  // Shared address / shutdown pin.
  input  wire logic        bus_addr_select_in,
  output logic             bus_addr_select_out,
  output logic             shared_pin_out,
  output logic             shared_pin_oe_out,
  // Alert levels and converter controls.
  output logic             overtemp_alert_out,
  output logic             crit_alert_out,
  output logic             diode_model_out,
  output logic             remote_filter_bit_hi,
  output logic             remote_filter_bit_lo,
  output logic             remote_filter_en_out,
  output logic [10:0]      remote_offset_out,
  output logic             standby_out,
  output logic             one_shot_start_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0] diode_config;                 // Stored bits 6..1 only.
  logic [7:0] general_config;               // Stored writable bits only.
  logic [7:0] remote_offset_high;           // Sign and integer part.
  logic [7:0] remote_offset_low;            // Fraction in bits 7..5.
  logic [7:0] live_msb [TSDC_NCHAN];        // Latest high bytes.
  logic [7:0] live_lsb [TSDC_NCHAN];        // Latest low bytes.
  logic [7:0] frozen_lsb [TSDC_NCHAN];      // Low byte held for the host.
  logic [TSDC_NCHAN-1:0] locked;            // Freeze flags.
  logic [TSDC_NCHAN-1:0] msb_rd;            // High byte read this cycle.
  logic [TSDC_NCHAN-1:0] lsb_rd;            // Low byte read this cycle.
  logic [7:0] next_rd_data;                 // Read mux result.

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the temperature byte offsets, used for both halves.
  function automatic logic [TSDC_NCHAN-1:0] msb_hit(input logic [7:0] a);
    msb_hit = {a == TSDC_OFS_RUNS_MSB, a == TSDC_OFS_RSIGN_MSB, a == TSDC_OFS_LOCAL_MSB};
  endfunction

  function automatic logic [TSDC_NCHAN-1:0] lsb_hit(input logic [7:0] a);
    lsb_hit = {a == TSDC_OFS_RUNS_LSB, a == TSDC_OFS_RSIGN_LSB, a == TSDC_OFS_LOCAL_LSB};
  endfunction

  // Read strobes per channel.
  assign msb_rd = req_in.rd ? msb_hit(req_in.addr) : '0;
  assign lsb_rd = req_in.rd ? lsb_hit(req_in.addr) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Live conversion results; these always follow the converter.
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < TSDC_NCHAN; i++)
      begin
        live_msb[i] <= TSDC_RST_TEMP;
        live_lsb[i] <= TSDC_RST_TEMP;
      end
    end
    else if (conv_in.valid)
    begin
      live_msb[0] <= conv_in.local_msb;
      live_lsb[0] <= conv_in.local_lsb;
      live_msb[1] <= conv_in.rsign_msb;
      live_lsb[1] <= conv_in.rsign_lsb;
      live_msb[2] <= conv_in.runs_msb;
      live_lsb[2] <= conv_in.runs_lsb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte freezing. The freeze copies the live low byte in the same cycle as
  // the high byte is returned, so the pair always comes from one conversion,
  // provided the host reads the high byte first. // [RULE_01]
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      locked <= '0;
      for (int i = 0; i < TSDC_NCHAN; i++)
      begin
        frozen_lsb[i] <= TSDC_RST_TEMP;
      end
    end
    else
    begin
      for (int i = 0; i < TSDC_NCHAN; i++)
      begin
        if (msb_rd[i])
        begin
          // Each high read takes a fresh copy, overriding an older one.
          locked[i]     <= 1'b1;        // [RULE_02]
          frozen_lsb[i] <= live_lsb[i]; // [RULE_04]
        end
        else if (lsb_rd[i])
        begin
          // Reading the low byte hands it back to the converter.
          locked[i] <= 1'b0; // [RULE_03]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and offset writes; reserved bits are never stored.
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      diode_config       <= TSDC_RST_DIODE_CFG & TSDC_DCFG_WMASK; // [RULE_10]
      general_config     <= TSDC_RST_GEN_CFG;
      remote_offset_high <= TSDC_RST_OFFSET; // [RULE_11]
      remote_offset_low  <= TSDC_RST_OFFSET; // [RULE_12]
    end
    else if (req_in.wr)
    begin
      case (req_in.addr)
        TSDC_OFS_DIODE_CFG: diode_config       <= req_in.wdata & TSDC_DCFG_WMASK;
        TSDC_OFS_GEN_CFG_A: general_config     <= req_in.wdata & TSDC_GCFG_WMASK; // [RULE_14]
        TSDC_OFS_GEN_CFG_B: general_config     <= req_in.wdata & TSDC_GCFG_WMASK; // [RULE_14]
        TSDC_OFS_OFFSET_HI: remote_offset_high <= req_in.wdata; // [RULE_11]
        TSDC_OFS_OFFSET_LO: remote_offset_low  <= req_in.wdata & TSDC_OFFLO_WMASK; // [RULE_12]
        default:            ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-shot: a write outside standby is dropped silently. // [RULE_13]
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      one_shot_start_out <= 1'b0;
    end
    else
    begin
      one_shot_start_out <= req_in.wr && (req_in.addr == TSDC_OFS_ONE_SHOT) &&
                            general_config[TSDC_GCFG_STANDBY]; // [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped offsets, including the one-shot, read zero.
  // The gated read strobes pick the channel, since the result is only stored on a read.
  always_comb
  begin
    next_rd_data = TSDC_UNMAPPED_DATA;
    for (int i = 0; i < TSDC_NCHAN; i++)
    begin
      if (msb_rd[i])
      begin
        next_rd_data = live_msb[i];
      end
      if (lsb_rd[i])
      begin
        next_rd_data = locked[i] ? frozen_lsb[i] : live_lsb[i]; // [RULE_02]
      end
    end
    case (req_in.addr)
      TSDC_OFS_DIODE_CFG: next_rd_data = diode_config | TSDC_DCFG_FIXED; // [RULE_10]
      TSDC_OFS_GEN_CFG_A: next_rd_data = general_config;
      TSDC_OFS_GEN_CFG_B: next_rd_data = general_config;
      TSDC_OFS_OFFSET_HI: next_rd_data = remote_offset_high;
      TSDC_OFS_OFFSET_LO: next_rd_data = remote_offset_low;
      default:            ;
    endcase
  end

  // Read data is registered and answered one cycle after the strobe.
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= req_in.rd;
      if (req_in.rd)
      begin
        rd_data_out <= next_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert combining and shared pin. The fault masks only hide the diode fault,
  // a real over-limit on a channel still asserts unless its own mask is set.
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      overtemp_alert_out  <= 1'b0;
      crit_alert_out      <= 1'b0;
      bus_addr_select_out <= 1'b0;
    end
    else
    begin
      overtemp_alert_out <= (remote_os_over_in & ~general_config[TSDC_GCFG_R_OSMASK]) | // [RULE_14]
                            (local_os_over_in & ~general_config[TSDC_GCFG_L_OSMASK]) |
                            (diode_fault_in & ~diode_config[TSDC_DCFG_OS_FMASK]); // [RULE_06]
      crit_alert_out <= (remote_crit_over_in & ~general_config[TSDC_GCFG_R_CRMASK]) | // [RULE_14]
                        (local_crit_over_in & ~general_config[TSDC_GCFG_L_CRMASK]) |
                        (diode_fault_in & ~diode_config[TSDC_DCFG_CR_FMASK]); // [RULE_07]
      // The address level is only passed on while the pin is an input.
      bus_addr_select_out <= ~diode_config[TSDC_DCFG_PIN_FN] & bus_addr_select_in; // [RULE_05]
    end
  end

  // Open-drain shutdown: drive low only while alerting in shutdown mode.
  assign shared_pin_out    = 1'b0;
  assign shared_pin_oe_out = diode_config[TSDC_DCFG_PIN_FN] & overtemp_alert_out; // [RULE_05]

  // Converter controls straight from the registers.
  assign diode_model_out      = diode_config[TSDC_DCFG_MODEL]; // [RULE_08]
  assign remote_filter_bit_hi = diode_config[TSDC_DCFG_FILT_HI];
  assign remote_filter_bit_lo = diode_config[TSDC_DCFG_FILT_LO];
  // Reserved filter codes leave the filter off rather than half-on.
  assign remote_filter_en_out = {remote_filter_bit_hi, remote_filter_bit_lo} == TSDC_FILT_ON; // [RULE_09]
  assign remote_offset_out    = {remote_offset_high, remote_offset_low[7:5]}; // [RULE_11]
  assign standby_out          = general_config[TSDC_GCFG_STANDBY]; // [RULE_14]

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  chk_lock_on_msb: assert property (msb_rd[1] |=> locked[1] && frozen_lsb[1] == $past(live_lsb[1])) // [RULE_02]
    else $error("High byte read did not freeze its low byte.");
  chk_frozen_hold: assert property (locked[0] && !msb_rd[0] && conv_in.valid |=> $stable(frozen_lsb[0])) // [RULE_02]
    else $error("Frozen low byte changed under a conversion.");
  chk_lsb_release: assert property (lsb_rd[2] && !msb_rd[2] |=> !locked[2]) // [RULE_03]
    else $error("Low byte read did not release the freeze.");
  chk_relock_newer: assert property (locked[0] && msb_rd[0] |=> frozen_lsb[0] == $past(live_lsb[0])) // [RULE_04]
    else $error("Second high byte read did not replace the frozen value.");
  chk_dcfg_fixed: assert property (req_in.rd && req_in.addr == TSDC_OFS_DIODE_CFG |=> !rd_data_out[7] && rd_data_out[0]) // [RULE_10]
    else $error("Diode config reserved bits read wrong.");
  chk_offlo_zero: assert property (req_in.rd && req_in.addr == TSDC_OFS_OFFSET_LO |=> rd_data_out[4:0] == 5'h00) // [RULE_12]
    else $error("Offset low byte unused bits not zero.");
  chk_fault_os: assert property (diode_fault_in && !diode_config[TSDC_DCFG_OS_FMASK] |=> overtemp_alert_out) // [RULE_06]
    else $error("Unmasked diode fault did not raise overtemp.");
  chk_fault_crit: assert property (diode_fault_in && !remote_crit_over_in && !local_crit_over_in &&
                                   diode_config[TSDC_DCFG_CR_FMASK] |=> !crit_alert_out) // [RULE_07]
    else $error("Masked diode fault reached critical output.");
  chk_pin_func: assert property (diode_config[TSDC_DCFG_PIN_FN] |=> !bus_addr_select_out) // [RULE_05]
    else $error("Address level passed on while the pin is the shutdown output.");
  chk_pin_drive: assert property (shared_pin_oe_out |-> diode_config[TSDC_DCFG_PIN_FN] && overtemp_alert_out) // [RULE_05]
    else $error("Shared pin driven while in address mode.");
  chk_one_shot: assert property (req_in.wr && req_in.addr == TSDC_OFS_ONE_SHOT && !standby_out |=> !one_shot_start_out) // [RULE_13]
    else $error("One-shot started outside standby.");
  chk_filter_code: assert property (remote_filter_en_out |-> diode_config[2:1] == 2'h3) // [RULE_09]
    else $error("Filter enabled by a reserved code.");

  cov_pair_read: cover property (msb_rd[1] ##[1:4] lsb_rd[1]);
  cov_conv_locked: cover property (locked[1] && conv_in.valid ##[1:4] lsb_rd[1]);
  cov_one_shot: cover property (one_shot_start_out);
  cov_shutdown: cover property (shared_pin_oe_out);

endmodule
`default_nettype wire

//--- verif/tsdc_host_model.sv
// Host-side model that issues register accesses and conversion results to the register bank.
`timescale 1ns/10ps
`default_nettype none
module tsdc_host_model
  import tsdc_pkg::*;
(
  // Clock.
  input  wire logic       core_clk_in,
  // Read answer from the bank.
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  // Requests and conversion results toward the bank.
  output var tsdc_req_t   req_out,
  output var tsdc_conv_t  conv_out
);
  // Idle bus at time zero so the bank never sees an unknown strobe.
  initial
  begin
    req_out  = '0;
    conv_out = '0;
  end

  // Read: strobe for one edge, take the answer one cycle later, then scramble the released fields.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge core_clk_in);
    req_out.rd   = 1'h1;
    req_out.addr = addr;
    @(negedge core_clk_in);
    data         = rd_data_in;
    ok           = rd_valid_in;
    req_out.rd   = 1'h0;
    req_out.addr = ~addr;
  endtask

  // Write: strobe for one edge; the bank gives no answer.
  task automatic wr(input logic [7:0] addr, input logic [7:0] wdata);
    @(negedge core_clk_in);
    req_out.wr    = 1'h1;
    req_out.addr  = addr;
    req_out.wdata = wdata;
    @(negedge core_clk_in);
    req_out.wr    = 1'h0;
    req_out.addr  = ~addr;
    req_out.wdata = ~wdata;
  endtask

  // Conversion: high bytes are v+40h, low byte of channel c is v+c, so a stale byte is told from a live one.
  task automatic convert(input logic [7:0] v);
    @(negedge core_clk_in);
    conv_out = '{1'h1, v + 8'h40, v, v + 8'h40, v + 8'h01, v + 8'h40, v + 8'h02};
    @(negedge core_clk_in);
    conv_out = {1'h0, ~conv_out[47:0]};
  endtask
endmodule
`default_nettype wire

//--- verif/tsdc_regs_tb_top.sv
// Self-checking testbench of the sensor register bank.
`timescale 1ns/10ps
`default_nettype none
module tsdc_regs_tb_top;
  import tsdc_pkg::*;
  logic       core_clk_in, srst_in, rd_valid, r_os, r_cr, l_os, l_cr, fault, asel;
  logic       asel_out, pin, pin_oe, os_out, cr_out, model, f_hi, f_lo, f_en, stby, shot;
  logic [7:0] rd_data;
  logic [10:0] ofs;
  tsdc_req_t  req;
  tsdc_conv_t conv;
  int         n_fail, n_checks, cycles;

  tsdc_regs DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .req_in(req), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .conv_in(conv), .remote_os_over_in(r_os), .remote_crit_over_in(r_cr),
    .local_os_over_in(l_os), .local_crit_over_in(l_cr), .diode_fault_in(fault),
    .bus_addr_select_in(asel), .bus_addr_select_out(asel_out), .shared_pin_out(pin),
    .shared_pin_oe_out(pin_oe), .overtemp_alert_out(os_out), .crit_alert_out(cr_out),
    .diode_model_out(model), .remote_filter_bit_hi(f_hi), .remote_filter_bit_lo(f_lo),
    .remote_filter_en_out(f_en), .remote_offset_out(ofs), .standby_out(stby), .one_shot_start_out(shot));

  tsdc_host_model host (.core_clk_in(core_clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .req_out(req), .conv_out(conv));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a hung bank still ends in the verdict.
  always #4 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared comparison, read and idle helpers.
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk1(input string nm, input logic seen, input logic exp);
    chk(nm, {10'h000, seen}, {10'h000, exp});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.rd(addr, d, ok);
    chk1("rd_valid", ok, 1'h1);
    chk(nm, {3'h0, d}, {3'h0, exp});
  endtask

  task automatic tick();
    @(negedge core_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rd_chk("dcfg_rst", TSDC_OFS_DIODE_CFG, 8'h1F);
    rd_chk("ofs_hi_rst", TSDC_OFS_OFFSET_HI, 8'h00);
    rd_chk("ofs_lo_rst", TSDC_OFS_OFFSET_LO, 8'h00);
    rd_chk("gcfg_rst", TSDC_OFS_GEN_CFG_B, 8'h00);
    chk1("model_rst", model, 1'h1);
    chk1("filt_rst", f_en, 1'h1);
    chk1("stby_rst", stby, 1'h0);
    chk("ofs_rst", ofs, 11'h000);
  endtask

  // Every channel: freeze, release, and refreeze over a newer conversion.
  // The host side reads the high byte before its low byte, except lo_released, which reads the low byte again after lo_frozen.
  task automatic t_lock();
    logic [7:0] hi [3];
    logic [7:0] lo [3];
    hi = '{TSDC_OFS_LOCAL_MSB, TSDC_OFS_RSIGN_MSB, TSDC_OFS_RUNS_MSB};
    lo = '{TSDC_OFS_LOCAL_LSB, TSDC_OFS_RSIGN_LSB, TSDC_OFS_RUNS_LSB};
    for (int c = 0; c < 3; c++)
    begin
      host.convert(8'h20);
      rd_chk("hi_live", hi[c], 8'h60);
      host.convert(8'h40);
      rd_chk("lo_frozen", lo[c], 8'h20 + 8'(c));
      rd_chk("lo_released", lo[c], 8'h40 + 8'(c));
      rd_chk("hi_again", hi[c], 8'h80);
      host.convert(8'h60);
      rd_chk("hi_refreeze", hi[c], 8'hA0);
      host.convert(8'h80);
      rd_chk("lo_refrozen", lo[c], 8'h60 + 8'(c));
    end
  endtask

  // Reserved bits, filter codes, model bit, pin function and fault masks.
  task automatic t_dcfg();
    logic [1:0] k;
    host.wr(TSDC_OFS_DIODE_CFG, 8'hFF);
    rd_chk("dcfg_fixed", TSDC_OFS_DIODE_CFG, 8'h7F);
    chk1("model_on", model, 1'h1);
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      host.wr(TSDC_OFS_DIODE_CFG, {5'h00, k, 1'h0});
      chk1("filt_en", f_en, k == 2'h3);
      chk("filt_bits", {9'h000, f_hi, f_lo}, {9'h000, k});
      chk1("model_off", model, 1'h0);
      rd_chk("dcfg_rb", TSDC_OFS_DIODE_CFG, {5'h00, k, 1'h1});
    end
    asel = 1'h1;
    fault = 1'h1;
    tick();
    tick();
    chk1("asel_in", asel_out, 1'h1);
    chk1("os_fault", os_out, 1'h1);
    chk1("cr_fault", cr_out, 1'h1);
    chk1("oe_addr", pin_oe, 1'h0);
    host.wr(TSDC_OFS_DIODE_CFG, 8'h40);
    tick();
    chk1("asel_off", asel_out, 1'h0);
    chk1("oe_os", pin_oe, 1'h1);
    chk1("pin_low", pin, 1'h0);
    host.wr(TSDC_OFS_DIODE_CFG, 8'h20);
    tick();
    chk1("os_masked", os_out, 1'h0);
    chk1("cr_kept", cr_out, 1'h1);
    host.wr(TSDC_OFS_DIODE_CFG, 8'h10);
    tick();
    chk1("os_kept", os_out, 1'h1);
    chk1("cr_masked", cr_out, 1'h0);
    fault = 1'h0;
    asel = 1'h0;
  endtask

  task automatic t_offset();
    host.wr(TSDC_OFS_OFFSET_HI, 8'h9A);
    host.wr(TSDC_OFS_OFFSET_LO, 8'hFF);
    rd_chk("ofs_hi", TSDC_OFS_OFFSET_HI, 8'h9A);
    rd_chk("ofs_lo", TSDC_OFS_OFFSET_LO, 8'hE0);
    chk("ofs_out", ofs, {8'h9A, 3'h7});
  endtask

  // One-shot refused while converting, honoured in standby; remote and local alert masks.
  task automatic t_gcfg();
    host.wr(TSDC_OFS_ONE_SHOT, 8'h01);
    chk1("shot_run", shot, 1'h0);
    r_os = 1'h1;
    r_cr = 1'h1;
    host.wr(TSDC_OFS_GEN_CFG_B, 8'hFF);
    rd_chk("gcfg_rb", TSDC_OFS_GEN_CFG_A, 8'h5E);
    chk1("stby_on", stby, 1'h1);
    chk1("ros_mask", os_out, 1'h0);
    chk1("rcr_mask", cr_out, 1'h0);
    host.wr(TSDC_OFS_GEN_CFG_A, 8'h40);
    chk1("shot_none", shot, 1'h0);
    tick();
    chk1("ros_live", os_out, 1'h1);
    chk1("rcr_live", cr_out, 1'h1);
    host.wr(TSDC_OFS_ONE_SHOT, 8'h01);
    chk1("shot_stby", shot, 1'h1);
    tick();
    chk1("shot_end", shot, 1'h0);
    rd_chk("unmapped", TSDC_OFS_ONE_SHOT, 8'h00);
    // Local over-limits alone: first hidden by mask bits 2 and 1, then passed on.
    {r_os, r_cr, l_os, l_cr} = 4'h3;
    host.wr(TSDC_OFS_GEN_CFG_A, 8'h46);
    tick();
    chk1("los_mask", os_out, 1'h0);
    chk1("lcr_mask", cr_out, 1'h0);
    host.wr(TSDC_OFS_GEN_CFG_A, 8'h40);
    tick();
    chk1("los_live", os_out, 1'h1);
    chk1("lcr_live", cr_out, 1'h1);
    {l_os, l_cr} = 2'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {core_clk_in, r_os, r_cr, l_os, l_cr, fault, asel} = 7'h00;
    srst_in = 1'h1;
    repeat (16) @(negedge core_clk_in);
    srst_in = 1'h0;
    t_reset();
    t_lock();
    t_dcfg();
    t_offset();
    t_gcfg();
    // A second reset in mid-run must bring every written register back to its default.
    srst_in = 1'h1;
    tick();
    tick();
    srst_in = 1'h0;
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
